// File: inc/ccf_pkg.sv
// Constants for the controller capability field bank: register indexes,
// field positions, reset values and the fused command encoding.
// Assumes a 32-bit APB register bus, one field per aligned word.

package ccf_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int IDX_W = 11;
    localparam int DATA_W = 32;
    localparam logic [1:0] WORD_ALIGN = 2'h0;

    // ------------------------------------------------------------------
    // Register indexes (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_CES = 11'h201;
    localparam logic [IDX_W-1:0] IDX_RSV_LO = 11'h202;
    localparam logic [IDX_W-1:0] IDX_RSV_HI = 11'h203;
    localparam logic [IDX_W-1:0] IDX_NSC = 11'h204;
    localparam logic [IDX_W-1:0] IDX_OCS = 11'h208;
    localparam logic [IDX_W-1:0] IDX_FOS = 11'h20a;
    localparam logic [IDX_W-1:0] IDX_FMA = 11'h20c;
    localparam logic [IDX_W-1:0] IDX_CTRL = 11'h400;
    localparam logic [IDX_W-1:0] IDX_STAT = 11'h401;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int CES_MAX_LSB = 4;
    localparam logic [3:0] CES_REQ = 4'h4;
    localparam logic [3:0] CES_MAX_REC = 4'h4;
    localparam int OCS_CMP_BIT = 0;
    localparam int OCS_WUNC_BIT = 1;
    localparam int OCS_DSM_BIT = 2;
    localparam int FOS_CW_BIT = 0;
    localparam int FMA_FMT_ALL_BIT = 0;
    localparam int FMA_ERASE_ALL_BIT = 1;
    localparam int FMA_CRYPTO_BIT = 2;
    localparam int CTRL_LOCK_BIT = 0;
    localparam int STAT_FUSE_ERR_BIT = 0;
    localparam int STAT_SCOPE_ALL_BIT = 1;
    localparam int STAT_NSID_BAD_BIT = 2;

    // ------------------------------------------------------------------
    // Reset values and namespace numbering
    // ------------------------------------------------------------------
    localparam logic [31:0] NSC_RST = 32'h0000_0001;
    localparam logic [31:0] NSID_FIRST = 32'h0000_0001;
    localparam logic [31:0] NSID_NONE = 32'h0000_0000;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Fused command encoding and register selector
    // ------------------------------------------------------------------
    localparam logic [1:0] FUSE_NONE = 2'h0;
    localparam logic [1:0] FUSE_FIRST = 2'h1;
    localparam logic [1:0] FUSE_SECOND = 2'h2;

    typedef enum logic [3:0] {
        REG_NONE, REG_CES, REG_RSV, REG_NSC, REG_OCS,
        REG_FOS, REG_FMA, REG_CTRL, REG_STAT
    } ccf_reg_t;

endpackage : ccf_pkg

// File: hdl/ccf_fuse_chk.sv
// Fused compare-and-write sequence checker.
// Assumes commands arrive on the controller clock, one per valid cycle.

`timescale 1ns/1ps

module ccf_fuse_chk
    import ccf_pkg::*;
#(
    parameter int OPC_W = 8,
    parameter logic [OPC_W-1:0] OPC_COMPARE = 8'h05,
    parameter logic [OPC_W-1:0] OPC_WRITE = 8'h01
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Capability
    input wire logic fuse_en,
    // Command stream
    input wire logic cmd_valid,
    input wire logic [OPC_W-1:0] cmd_opcode,
    input wire logic [1:0] cmd_fuse,
    // Verdicts
    output logic pair_ok,
    output logic seq_err,
    output logic pair_open
);

    typedef enum logic {FS_IDLE, FS_OPEN} ccf_fs_t;

    typedef struct packed {
        ccf_fs_t st;
        logic ok;
        logic err;
    } ccf_fuse_st_t;

    ccf_fuse_st_t r;
    ccf_fuse_st_t nxt;

    // ------------------------------------------------------------------
    // Sequence tracking
    // ------------------------------------------------------------------
    // A broken pair is dropped whole; the second half never runs alone
    always_comb
    begin
        nxt = r;
        nxt.ok = 1'b0;
        nxt.err = 1'b0;
        if (cmd_valid)
        begin
            unique case (r.st)
                FS_IDLE:
                begin
                    if (cmd_fuse == FUSE_FIRST)
                    begin
                        if (fuse_en && cmd_opcode == OPC_COMPARE)
                            nxt.st = FS_OPEN;
                        else
                            nxt.err = 1'b1;
                    end
                    else if (cmd_fuse != FUSE_NONE)
                        nxt.err = 1'b1;
                end
                FS_OPEN:
                begin
                    nxt.st = FS_IDLE;
                    if (cmd_fuse == FUSE_SECOND && cmd_opcode == OPC_WRITE)
                        nxt.ok = 1'b1;
                    else
                        nxt.err = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            r <= '{st: FS_IDLE, ok: 1'b0, err: 1'b0};
        else
            r <= nxt;
    end

    assign pair_ok = r.ok;
    assign seq_err = r.err;
    assign pair_open = (r.st == FS_OPEN);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_open_cmp;
        cmd_valid && !pair_open && cmd_fuse == FUSE_FIRST;
    endsequence

    a_compare_leads: assert property (@(posedge clk) disable iff (!rst_n)
        s_open_cmp |=> (pair_open == ($past(cmd_opcode) == OPC_COMPARE && $past(fuse_en))))
        else $error("fused pair opened by a non-compare command");

    a_fused_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !fuse_en && cmd_valid && cmd_fuse == FUSE_FIRST |=> seq_err && !pair_open)
        else $error("fused pair accepted while unsupported");

endmodule : ccf_fuse_chk

// File: hdl/ccf_id_regs.sv
// Controller capability field bank: completion entry size, namespace
// count, optional command and fused support, format attributes.
// Assumes an APB master on MCLK and command/format requests from logic
// on the same clock.

`timescale 1ns/1ps

// Summary of operation
// - Upper nibble of byte 513 is maximum completion size, never below required.
// - Maximum completion entry size exponent recommended as 4, sixteen bytes.
// - Lower nibble of byte 513 is required completion size, fixed at 4.
// - Bytes 516 to 519 report the namespace count as 32 bits.
// - Namespaces are numbered 1 to count with no gaps.
// - Optional command field: bit2 dataset management, bit1 write-uncorrectable, bit0 compare.
// - Fused field bit 0 reports compare-then-write support, other bits zero.
// - In a fused pair compare must come first.
// - Format attributes bit 2 reports cryptographic erase support.
// - Format attributes bit 1 makes secure erase reach all namespaces.
// - Format attributes bit 0 makes format reach all namespaces alike.
module ccf_id_regs
    import ccf_pkg::*;
#(
    parameter logic [3:0] CES_MAX = CES_MAX_REC,
    parameter logic [31:0] NSC_DEFAULT = NSC_RST,
    parameter bit SUP_COMPARE = 1'b1,
    parameter bit SUP_WRITE_UNC = 1'b1,
    parameter bit SUP_DSM = 1'b1,
    parameter bit SUP_FUSED_CW = 1'b1,
    parameter bit FMA_CRYPTO = 1'b0,
    parameter bit FMA_ERASE_ALL = 1'b1,
    parameter bit FMA_FMT_ALL = 1'b0
)
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [DATA_W-1:0] PWDATA,
    output logic [DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Command stream
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_OPCODE,
    input wire logic [1:0] CMD_FUSE,
    output logic FUSE_OK,
    output logic FUSE_ERR,
    output logic FUSE_OPEN,
    // Format request
    input wire logic FMT_REQ,
    input wire logic [31:0] FMT_NSID,
    input wire logic FMT_SECURE,
    output logic FMT_ACK,
    output logic FMT_ALL,
    output logic FMT_BAD,
    output logic [31:0] FMT_FIRST,
    output logic [31:0] FMT_LAST
);

    // ------------------------------------------------------------------
    // Constant capability words
    // ------------------------------------------------------------------
    // The maximum is clamped so a bad parameter cannot undercut the minimum
    localparam logic [3:0] CES_MAX_EFF = (CES_MAX < CES_REQ) ? CES_REQ : CES_MAX;
    localparam logic [7:0] CES_BYTE = {CES_MAX_EFF, CES_REQ};

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic pslverr;
        logic [31:0] nsc;
        logic lock;
        logic fuse_err_st;
        logic scope_all_st;
        logic bad_st;
        logic fmt_ack;
        logic fmt_all;
        logic fmt_bad;
        logic [31:0] fmt_first;
        logic [31:0] fmt_last;
    } ccf_state_t;

    ccf_state_t r;
    ccf_state_t nxt;
    logic [15:0] ocs_word;
    logic [15:0] fos_word;
    logic [7:0] fma_byte;
    logic fuse_ok;
    logic fuse_err;
    logic fuse_open;
    logic setup;
    logic access;
    ccf_reg_t sel_reg;
    logic fmt_scope_all;
    logic fmt_nsid_bad;

    // Reserved bits are tied low in every capability word
    always_comb
    begin
        ocs_word = 16'h0000;
        ocs_word[OCS_DSM_BIT] = SUP_DSM;
        ocs_word[OCS_WUNC_BIT] = SUP_WRITE_UNC;
        ocs_word[OCS_CMP_BIT] = SUP_COMPARE;
        fos_word = 16'h0000;
        fos_word[FOS_CW_BIT] = SUP_FUSED_CW;
        fma_byte = 8'h00;
        fma_byte[FMA_CRYPTO_BIT] = FMA_CRYPTO;
        fma_byte[FMA_ERASE_ALL_BIT] = FMA_ERASE_ALL;
        fma_byte[FMA_FMT_ALL_BIT] = FMA_FMT_ALL;
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Misaligned addresses decode to nothing and are answered with an error
    function automatic ccf_reg_t decode(input logic [ADDR_W-1:0] addr);
        logic [IDX_W-1:0] idx;
        idx = addr[ADDR_W-1:2];
        decode = REG_NONE;
        if (addr[1:0] == WORD_ALIGN)
        begin
            unique case (idx)
                IDX_CES: decode = REG_CES;
                IDX_RSV_LO, IDX_RSV_HI: decode = REG_RSV;
                IDX_NSC: decode = REG_NSC;
                IDX_OCS: decode = REG_OCS;
                IDX_FOS: decode = REG_FOS;
                IDX_FMA: decode = REG_FMA;
                IDX_CTRL: decode = REG_CTRL;
                IDX_STAT: decode = REG_STAT;
                default: decode = REG_NONE;
            endcase
        end
    endfunction : decode

    function automatic logic [DATA_W-1:0] read_word(input ccf_reg_t sel, input ccf_state_t s);
        read_word = WORD_ZERO;
        unique case (sel)
            REG_CES: read_word[7:0] = CES_BYTE;
            REG_RSV: read_word = WORD_ZERO;
            REG_NSC: read_word = s.nsc;
            REG_OCS: read_word[15:0] = ocs_word;
            REG_FOS: read_word[15:0] = fos_word;
            REG_FMA: read_word[7:0] = fma_byte;
            REG_CTRL: read_word[CTRL_LOCK_BIT] = s.lock;
            REG_STAT:
            begin
                read_word[STAT_FUSE_ERR_BIT] = s.fuse_err_st;
                read_word[STAT_SCOPE_ALL_BIT] = s.scope_all_st;
                read_word[STAT_NSID_BAD_BIT] = s.bad_st;
            end
            REG_NONE: read_word = WORD_ZERO;
        endcase
    endfunction : read_word

    assign setup = PSEL && !PENABLE;
    assign access = PSEL && PENABLE;
    assign sel_reg = decode(PADDR);

    // ------------------------------------------------------------------
    // Fused pair checker
    // ------------------------------------------------------------------
    ccf_fuse_chk #(
        .OPC_W(8)
    ) u_fuse (
        .clk(MCLK),
        .rst_n(RST_N),
        .fuse_en(SUP_FUSED_CW),
        .cmd_valid(CMD_VALID),
        .cmd_opcode(CMD_OPCODE),
        .cmd_fuse(CMD_FUSE),
        .pair_ok(fuse_ok),
        .seq_err(fuse_err),
        .pair_open(fuse_open)
    );

    // ------------------------------------------------------------------
    // Format scope
    // ------------------------------------------------------------------
    // Secure erase widens to all namespaces when erase-all or format-all is set
    assign fmt_scope_all = FMA_FMT_ALL || (FMT_SECURE && FMA_ERASE_ALL);
    assign fmt_nsid_bad = (FMT_NSID < NSID_FIRST) || (FMT_NSID > r.nsc);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt = r;
        nxt.fmt_ack = 1'b0;
        // Read data is taken in setup so the access phase needs no wait
        if (setup)
        begin
            nxt.prdata = PWRITE ? WORD_ZERO : read_word(sel_reg, r);
            nxt.pslverr = (sel_reg == REG_NONE) ||
                          (PWRITE && !(sel_reg == REG_CTRL || sel_reg == REG_STAT ||
                                       (sel_reg == REG_NSC && !r.lock)));
        end
        // Writes land at the access edge, never twice
        if (access && PWRITE && !r.pslverr)
        begin
            unique case (sel_reg)
                REG_NSC: nxt.nsc = PWDATA;
                REG_CTRL: nxt.lock = r.lock || PWDATA[CTRL_LOCK_BIT];
                REG_STAT:
                begin
                    if (PWDATA[STAT_FUSE_ERR_BIT])
                        nxt.fuse_err_st = 1'b0;
                    if (PWDATA[STAT_NSID_BAD_BIT])
                        nxt.bad_st = 1'b0;
                end
                default: nxt.nsc = r.nsc;
            endcase
        end
        // Hardware events override a clear in the same cycle
        if (fuse_err)
            nxt.fuse_err_st = 1'b1;
        if (FMT_REQ)
        begin
            nxt.fmt_ack = 1'b1;
            nxt.fmt_bad = fmt_nsid_bad;
            nxt.fmt_all = fmt_scope_all && !fmt_nsid_bad;
            nxt.scope_all_st = fmt_scope_all;
            if (fmt_nsid_bad)
            begin
                nxt.bad_st = 1'b1;
                nxt.fmt_first = NSID_NONE;
                nxt.fmt_last = NSID_NONE;
            end
            else if (fmt_scope_all)
            begin
                nxt.fmt_first = NSID_FIRST;
                nxt.fmt_last = r.nsc;
            end
            else
            begin
                nxt.fmt_first = FMT_NSID;
                nxt.fmt_last = FMT_NSID;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            r <= '0;
            r.nsc <= NSC_DEFAULT;
        end
        else
            r <= nxt;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign PREADY = 1'b1; // Zero wait states
    assign PRDATA = r.prdata;
    assign PSLVERR = r.pslverr && access;
    assign FUSE_OK = fuse_ok;
    assign FUSE_ERR = fuse_err;
    assign FUSE_OPEN = fuse_open;
    assign FMT_ACK = r.fmt_ack;
    assign FMT_ALL = r.fmt_all;
    assign FMT_BAD = r.fmt_bad;
    assign FMT_FIRST = r.fmt_first;
    assign FMT_LAST = r.fmt_last;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    sequence s_rd(logic [IDX_W-1:0] i);
        PSEL && !PENABLE && !PWRITE && PADDR == {i, WORD_ALIGN};
    endsequence

    sequence s_fmt(logic secure);
        FMT_REQ && FMT_SECURE == secure && !fmt_nsid_bad;
    endsequence

    a_ces_order: assert property (
        s_rd(IDX_CES) |=> PRDATA[7:4] >= PRDATA[3:0] && PRDATA[31:8] == 24'h0)
        else $error("completion maximum below required size");
    a_ces_req: assert property (
        s_rd(IDX_CES) |=> PRDATA[3:0] == CES_REQ)
        else $error("required completion size wrong");
    a_ces_rec: assert property (
        s_rd(IDX_CES) |=> CES_MAX != CES_MAX_REC || PRDATA[7:4] == CES_MAX_REC)
        else $error("recommended completion maximum not reported");
    a_nsc_read: assert property (
        s_rd(IDX_NSC) |=> PRDATA == $past(r.nsc) && !PSLVERR)
        else $error("namespace count read wrong");
    a_nsid_range: assert property (
        FMT_REQ && (FMT_NSID == NSID_NONE || FMT_NSID > r.nsc) |=> FMT_ACK && FMT_BAD)
        else $error("out-of-range namespace accepted");
    a_ocs_bits: assert property (
        s_rd(IDX_OCS) |=> PRDATA[31:3] == 29'h0 && PRDATA[OCS_DSM_BIT] == SUP_DSM)
        else $error("optional command field wrong");
    a_fos_bits: assert property (
        s_rd(IDX_FOS) |=> PRDATA == {31'h0, SUP_FUSED_CW})
        else $error("fused support field wrong");
    a_fused_flag: assert property (
        FUSE_ERR |=> r.fuse_err_st)
        else $error("fused order error not recorded");
    a_fma_crypto: assert property (
        s_rd(IDX_FMA) |=> PRDATA[FMA_CRYPTO_BIT] == FMA_CRYPTO && PRDATA[31:3] == 29'h0)
        else $error("crypto erase bit wrong");
    a_erase_scope: assert property (
        s_fmt(1'b1) |=> FMT_ALL == (FMA_ERASE_ALL || FMA_FMT_ALL) &&
                        (FMT_ALL || FMT_FIRST == FMT_LAST))
        else $error("secure erase scope wrong");
    a_fmt_scope: assert property (
        s_fmt(1'b0) |=> FMT_ALL == FMA_FMT_ALL &&
                        (!FMT_ALL || (FMT_FIRST == NSID_FIRST && FMT_LAST == $past(r.nsc))))
        else $error("format scope wrong");
    a_rsv_zero: assert property (
        s_rd(IDX_RSV_LO) or s_rd(IDX_RSV_HI) |=> PRDATA == WORD_ZERO)
        else $error("reserved bytes not zero");

endmodule : ccf_id_regs

// File: dv/ccf_host_mdl.sv
// Host-side model: APB master, command source and format requester.
// Assumes one clock shared with the capability bank, inputs on MCLK.

`timescale 1ns/1ps

module ccf_host_mdl
    import ccf_pkg::*;
(
    // Clock
    input wire logic clk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Commands and format requests
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic [1:0] cmd_fuse,
    output logic fmt_req,
    output logic [31:0] fmt_nsid,
    output logic fmt_secure
);
    // Idle bus at time zero
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {cmd_valid, cmd_opcode, cmd_fuse, fmt_req, fmt_nsid, fmt_secure} = '0;
    end

    // One APB transfer; waits for pready, then releases and scrambles the
    // address and data so a stale value never looks valid
    task automatic xfer(input logic wr, input logic [IDX_W-1:0] idx,
        input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, WORD_ALIGN};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // Only the bench watchdog ends a wait that never answers
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask : xfer

    // One command pulse; returns at the falling edge after it is taken
    task automatic cmd(input logic [7:0] opc, input logic [1:0] fuse);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_opcode <= opc;
        cmd_fuse <= fuse;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_opcode <= ~opc;
        @(negedge clk);
    endtask : cmd

    // One format request pulse; returns inside the single acknowledge cycle
    task automatic fmt(input logic [31:0] nsid, input logic sec);
        @(posedge clk);
        fmt_req <= 1'b1;
        fmt_nsid <= nsid;
        fmt_secure <= sec;
        @(posedge clk);
        fmt_req <= 1'b0;
        fmt_nsid <= ~nsid;
        @(negedge clk);
    endtask : fmt
endmodule : ccf_host_mdl

// File: dv/controller_capability_fields_tb.sv
// Self-checking bench for the capability field bank.
// Assumes default design parameters and zero-wait APB answers.

`timescale 1ns/1ps

module controller_capability_fields_tb;
    import ccf_pkg::*;

    localparam logic [7:0] OPC_CMP = 8'h05;
    localparam logic [7:0] OPC_WR = 8'h01;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, fmt_nsid, fmt_first, fmt_last;
    logic cmd_valid, fuse_ok, fuse_err, fuse_open;
    logic fmt_req, fmt_secure, fmt_ack, fmt_all, fmt_bad;
    logic [7:0] cmd_opcode;
    logic [1:0] cmd_fuse;
    int err_count = 0;
    int samples_checked = 0;

    // ------------------------------------------------------------------
    // Clock, design and host
    // ------------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    ccf_id_regs i_dut (
        .MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CMD_VALID(cmd_valid), .CMD_OPCODE(cmd_opcode),
        .CMD_FUSE(cmd_fuse), .FUSE_OK(fuse_ok), .FUSE_ERR(fuse_err), .FUSE_OPEN(fuse_open),
        .FMT_REQ(fmt_req), .FMT_NSID(fmt_nsid), .FMT_SECURE(fmt_secure), .FMT_ACK(fmt_ack),
        .FMT_ALL(fmt_all), .FMT_BAD(fmt_bad), .FMT_FIRST(fmt_first), .FMT_LAST(fmt_last)
    );

    ccf_host_mdl i_host (
        .clk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_fuse(cmd_fuse),
        .fmt_req(fmt_req), .fmt_nsid(fmt_nsid), .fmt_secure(fmt_secure)
    );

    // ------------------------------------------------------------------
    // Compare and access helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic access(input logic wr, input logic [IDX_W-1:0] idx,
        input logic [31:0] wd, input logic [31:0] exp, input logic exp_err);
        logic [31:0] d;
        logic e;
        i_host.xfer(wr, idx, wd, d, e);
        if (!wr)
            check(d, exp);
        check({31'h0, e}, {31'h0, exp_err});
    endtask : access

    // Flags are {ok, err, open}
    task automatic fuse(input logic [7:0] opc, input logic [1:0] f, input logic [2:0] exp);
        i_host.cmd(opc, f);
        check({29'h0, fuse_ok, fuse_err, fuse_open}, {29'h0, exp});
    endtask : fuse

    // Flags are {ack, all, bad}; ack is looked at in its single cycle
    task automatic fmt(input logic [31:0] nsid, input logic sec, input logic [2:0] exp,
        input logic [31:0] first, input logic [31:0] last);
        i_host.fmt(nsid, sec);
        check({29'h0, fmt_ack, fmt_all, fmt_bad}, {29'h0, exp});
        check(fmt_first, first);
        check(fmt_last, last);
    endtask : fmt

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        // Constant words, reserved space and refused writes
        access(1'b0, IDX_CES, WORD_ZERO, 32'h0000_0044, 1'b0);
        access(1'b0, IDX_RSV_LO, WORD_ZERO, WORD_ZERO, 1'b0);
        access(1'b0, IDX_RSV_HI, WORD_ZERO, WORD_ZERO, 1'b0);
        access(1'b0, IDX_NSC, WORD_ZERO, 32'h0000_0001, 1'b0);
        access(1'b0, IDX_OCS, WORD_ZERO, 32'h0000_0007, 1'b0);
        access(1'b0, IDX_FOS, WORD_ZERO, 32'h0000_0001, 1'b0);
        access(1'b0, IDX_FMA, WORD_ZERO, 32'h0000_0002, 1'b0);
        access(1'b0, 11'h205, WORD_ZERO, WORD_ZERO, 1'b1);
        access(1'b1, IDX_CES, 32'hffff_ff00, WORD_ZERO, 1'b1);
        access(1'b1, IDX_FMA, 32'hffff_ffff, WORD_ZERO, 1'b1);
        access(1'b0, IDX_CES, WORD_ZERO, 32'h0000_0044, 1'b0);
        access(1'b0, IDX_FMA, WORD_ZERO, 32'h0000_0002, 1'b0);
        $display("test fields done");
        // Namespace count and format scope
        access(1'b1, IDX_NSC, 32'h0000_0004, WORD_ZERO, 1'b0);
        access(1'b0, IDX_NSC, WORD_ZERO, 32'h0000_0004, 1'b0);
        fmt(32'h2, 1'b0, 3'b100, 32'h2, 32'h2);
        fmt(32'h2, 1'b1, 3'b110, 32'h1, 32'h4);
        fmt(32'h4, 1'b0, 3'b100, 32'h4, 32'h4);
        fmt(32'h5, 1'b0, 3'b101, WORD_ZERO, WORD_ZERO);
        fmt(32'h1, 1'b1, 3'b110, 32'h1, 32'h4);
        fmt(NSID_NONE, 1'b0, 3'b101, WORD_ZERO, WORD_ZERO);
        $display("test format done");
        // Fused pairs: legal order, wrong order, stray and broken halves
        fuse(OPC_CMP, FUSE_FIRST, 3'b001);
        fuse(OPC_WR, FUSE_SECOND, 3'b100);
        fuse(OPC_WR, FUSE_FIRST, 3'b010);
        fuse(OPC_WR, FUSE_SECOND, 3'b010);
        fuse(OPC_CMP, FUSE_FIRST, 3'b001);
        fuse(OPC_CMP, FUSE_NONE, 3'b010);
        access(1'b0, IDX_STAT, WORD_ZERO, 32'h0000_0005, 1'b0);
        $display("test fused done");
        // Sticky flags clear by writing ones; lock freezes the namespace count
        access(1'b1, IDX_STAT, 32'h0000_0005, WORD_ZERO, 1'b0);
        access(1'b0, IDX_STAT, WORD_ZERO, WORD_ZERO, 1'b0);
        access(1'b1, IDX_CTRL, 32'h0000_0001, WORD_ZERO, 1'b0);
        access(1'b0, IDX_CTRL, WORD_ZERO, 32'h0000_0001, 1'b0);
        access(1'b1, IDX_NSC, 32'h0000_0009, WORD_ZERO, 1'b1);
        access(1'b0, IDX_NSC, WORD_ZERO, 32'h0000_0004, 1'b0);
        $display("test lock done");
        give_verdict();
    end

    // Watchdog: the tests need under a hundred cycles
    initial
    begin
        repeat (5000) @(posedge mclk);
        err_count++;
        give_verdict();
    end
endmodule : controller_capability_fields_tb
